// *** rtl/sbd_pkg.sv ***
// shared constants and types of the stepper bus command decoder
package sbd_pkg;

    // fixed part of the own slave address and the general call address
    localparam logic [1:0] ADDR_FIXED_HI = 2'h3;
    localparam logic [6:0] GC_ADDR = 7'h00;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;

    // frame geometry
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] MAX_BYTES = 4'h8;
    localparam logic [3:0] ADDR_BYTE_IDX = 4'h0;
    localparam logic [3:0] CMD_BYTE_IDX = 4'h1;

    // level put on the data line while acknowledging
    localparam logic SDA_DRIVE_LEVEL = 1'b0;

    // command byte codes
    localparam logic [7:0] CMD_COMPLETE_STATUS = 8'h81;
    localparam logic [7:0] CMD_POSITION_QUERY = 8'hfc;
    localparam logic [7:0] CMD_NVM_PARAM_QUERY = 8'h82;
    localparam logic [7:0] CMD_SAFE_PARK = 8'h84;
    localparam logic [7:0] CMD_IMMEDIATE_HALT = 8'h85;
    localparam logic [7:0] CMD_ZERO_ACTUAL_POS = 8'h86;
    localparam logic [7:0] CMD_RELOAD_DEFAULTS = 8'h87;
    localparam logic [7:0] CMD_TWO_STAGE_MOVE = 8'h88;
    localparam logic [7:0] CMD_MOTOR_CONFIG_WRITE = 8'h89;
    localparam logic [7:0] CMD_TARGET_WRITE = 8'h8b;
    localparam logic [7:0] CMD_DECELERATE_HALT = 8'h8f;
    localparam logic [7:0] CMD_NVM_PROGRAM = 8'h90;
    localparam logic [7:0] CMD_STALL_CONFIG_WRITE = 8'h96;
    localparam logic [7:0] CMD_CONTINUOUS_RUN = 8'h97;
    localparam logic [7:0] CMD_BACK_EMF_PROBE = 8'h9f;

    // one-cycle command strobes towards the motion controller
    typedef struct packed {
        logic complete_status_query_cmd;
        logic position_query_cmd;
        logic nvm_param_query_cmd;
        logic safe_park_cmd;
        logic immediate_halt_cmd;
        logic zero_actual_pos_cmd;
        logic reload_defaults_cmd;
        logic two_stage_move_cmd;
        logic motor_config_write_cmd;
        logic target_write_cmd;
        logic decelerate_halt_cmd;
        logic nvm_program_cmd;
        logic stall_config_write_cmd;
        logic continuous_run_cmd;
        logic back_emf_probe_cmd;
    } sbd_cmd_t;

    // latched fault flags cleared by the complete status query
    typedef struct packed {
        logic thermal_warning_flag;
        logic thermal_shutdown_flag;
        logic undervoltage_flag;
        logic electrical_defect_flag;
        logic missed_step_flag;
        logic charge_pump_fault_flag;
        logic overcurrent_flag_a;
        logic overcurrent_flag_b;
        logic supply_reset_flag;
    } sbd_flags_t;

    typedef enum logic [1:0] {
        LS_IDLE,
        LS_RX,
        LS_ACK,
        LS_TX
    } sbd_link_st_t;

endpackage

// *** rtl/sbd_sync.sv ***
// two flip-flop level synchroniser
`timescale 1ns/1ns
module sbd_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // refused at elaboration: a zero-width synchroniser would silently pass nothing
    if (W < 1) begin : g_width_check
        $error("sbd_sync: width must be at least one");
    end

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sbd_sync_st_t;

    sbd_sync_st_t s_q;
    sbd_sync_st_t s_d;

    // the first stage feeds only the second stage
    always_comb begin
        s_d.meta = din;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.stable;
endmodule

// *** rtl/sbd_decoder.sv ***
// bus front end and command byte decoder of the stepper positioner
`timescale 1ns/1ns
module sbd_decoder
    import sbd_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic hardwired_address_pin,
    input wire logic prog_addr_bit_3,
    input wire logic prog_addr_bit_2,
    input wire logic prog_addr_bit_1,
    input wire logic prog_addr_bit_0,
    input wire sbd_pkg::sbd_flags_t fault_evt,
    output sbd_pkg::sbd_flags_t fault_flags,
    output sbd_pkg::sbd_cmd_t cmd,
    output logic cmd_valid,
    output logic cmd_unknown,
    output logic cmd_general_call,
    output logic [7:0] last_cmd
);
    import sbd_pkg::*;

    // ---------------- link domain, clocked by link_clk ----------------

    typedef struct packed {
        logic scl_p;
        logic sda_p;
        sbd_link_st_t st;
        logic [3:0] bitcnt;
        logic [3:0] bytecnt;
        logic [7:0] shreg;
        logic selected;
        logic rd;
        logic gc;
        logic ack_pend;
        logic oe;
        logic evt_tog;
        logic [7:0] evt_byte;
        logic evt_gc;
    } sbd_link_t;

    sbd_link_t l_q;
    sbd_link_t l_d;

    logic [6:0] lsync;
    logic s_scl;
    logic s_sda;
    logic s_hw;
    logic [3:0] s_prog;

    // the address bits come from another domain and change rarely, so a level sync is enough
    sbd_sync #(
        .W(7)
    ) u_link_sync (
        .clock(link_clk),
        .rstn(rstn),
        .din({scl_i, sda_i, hardwired_address_pin, prog_addr_bit_3, prog_addr_bit_2, prog_addr_bit_1,
              prog_addr_bit_0}),
        .dout(lsync)
    );

    assign s_scl = lsync[6];
    assign s_sda = lsync[5];
    assign s_hw = lsync[4];
    assign s_prog = lsync[3:0];

    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic [7:0] nb;
        logic own_hit;
        logic gc_hit;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_c = 1'b0;
        stop_c = 1'b0;
        nb = '0;
        own_hit = 1'b0;
        gc_hit = 1'b0;

        l_d = l_q;
        l_d.scl_p = s_scl;
        l_d.sda_p = s_sda;
        scl_rise = s_scl & ~l_q.scl_p;
        scl_fall = ~s_scl & l_q.scl_p;
        start_c = l_q.scl_p & s_scl & l_q.sda_p & ~s_sda;
        stop_c = l_q.scl_p & s_scl & ~l_q.sda_p & s_sda;
        nb = {l_q.shreg[6:0], s_sda};

        // a start, repeated or not, always restarts address reception
        if (start_c) begin
            l_d.st = LS_RX;
            l_d.bitcnt = '0;
            l_d.bytecnt = ADDR_BYTE_IDX;
            l_d.selected = 1'b0;
            l_d.rd = 1'b0;
            l_d.gc = 1'b0;
            l_d.ack_pend = 1'b0;
            l_d.oe = 1'b0;
        end else if (stop_c) begin
            l_d.st = LS_IDLE;
            l_d.selected = 1'b0;
            l_d.oe = 1'b0;
        end else begin
            case (l_q.st)
                LS_IDLE: begin
                    l_d.oe = 1'b0;
                end
                LS_RX: begin
                    if (scl_rise && (l_q.bitcnt < BYTE_BITS)) begin
                        l_d.shreg = nb;
                        l_d.bitcnt = l_q.bitcnt + 4'h1;
                        if (l_q.bitcnt == (BYTE_BITS - 4'h1)) begin
                            if (l_q.bytecnt == ADDR_BYTE_IDX) begin
                                own_hit = (nb[7:6] == ADDR_FIXED_HI) && (nb[5:2] == s_prog) && (nb[1] == s_hw);
                                gc_hit = (nb[7:1] == GC_ADDR) && (nb[0] == RW_WRITE);
                                l_d.ack_pend = own_hit | gc_hit;
                                l_d.selected = own_hit | gc_hit;
                                l_d.rd = own_hit & (nb[0] == RW_READ);
                                l_d.gc = gc_hit;
                            end else begin
                                // bytes past the limit are refused with a not-acknowledge
                                l_d.ack_pend = l_q.selected && (l_q.bytecnt < MAX_BYTES);
                                if (l_q.selected && (l_q.bytecnt == CMD_BYTE_IDX)) begin
                                    // data is held until the next command byte, many bus bits later
                                    l_d.evt_byte = nb;
                                    l_d.evt_gc = l_q.gc;
                                    l_d.evt_tog = ~l_q.evt_tog;
                                end
                            end
                            if (l_q.bytecnt != MAX_BYTES) begin
                                l_d.bytecnt = l_q.bytecnt + 4'h1;
                            end
                        end
                    end else if (scl_fall && (l_q.bitcnt == BYTE_BITS)) begin
                        if (l_q.ack_pend) begin
                            l_d.oe = 1'b1;
                            l_d.st = LS_ACK;
                        end else begin
                            l_d.st = LS_IDLE;
                        end
                    end
                end
                LS_ACK: begin
                    if (scl_fall) begin
                        l_d.oe = 1'b0;
                        l_d.bitcnt = '0;
                        l_d.st = l_q.rd ? LS_TX : LS_RX;
                    end
                end
                LS_TX: begin
                    // response payload is not produced here: the line stays released and reads as ones
                    if (scl_rise) begin
                        if (l_q.bitcnt == BYTE_BITS) begin
                            l_d.bitcnt = '0;
                            if (l_q.bytecnt != MAX_BYTES) begin
                                l_d.bytecnt = l_q.bytecnt + 4'h1;
                            end
                            if (s_sda || (l_q.bytecnt >= MAX_BYTES)) begin
                                l_d.st = LS_IDLE;
                            end
                        end else begin
                            l_d.bitcnt = l_q.bitcnt + 4'h1;
                        end
                    end
                end
                default: begin
                    l_d.st = LS_IDLE;
                    l_d.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    assign sda_o = SDA_DRIVE_LEVEL;
    assign sda_oe = l_q.oe;

    // ---------------- device domain, clocked by clock ----------------

    typedef struct packed {
        logic tog_p;
        sbd_cmd_t cmd;
        logic valid;
        logic unknown;
        logic gc;
        logic [7:0] last;
        sbd_flags_t flags;
    } sbd_dev_t;

    sbd_dev_t d_q;
    sbd_dev_t d_d;
    logic tog_s;

    sbd_sync #(
        .W(1)
    ) u_dev_sync (
        .clock(clock),
        .rstn(rstn),
        .din(l_q.evt_tog),
        .dout(tog_s)
    );

    always_comb begin
        logic new_byte;
        logic clr;
        logic [7:0] b;
        new_byte = 1'b0;
        clr = 1'b0;
        b = '0;

        d_d = d_q;
        d_d.tog_p = tog_s;
        d_d.cmd = '0;
        d_d.valid = 1'b0;
        d_d.unknown = 1'b0;
        new_byte = tog_s ^ d_q.tog_p;
        b = l_q.evt_byte;

        if (new_byte) begin
            d_d.valid = 1'b1;
            d_d.last = b;
            d_d.gc = l_q.evt_gc;
            case (b)
                CMD_COMPLETE_STATUS: begin
                    d_d.cmd.complete_status_query_cmd = 1'b1;
                    clr = 1'b1;
                end
                CMD_POSITION_QUERY: begin
                    d_d.cmd.position_query_cmd = 1'b1;
                end
                CMD_NVM_PARAM_QUERY: begin
                    d_d.cmd.nvm_param_query_cmd = 1'b1;
                end
                CMD_IMMEDIATE_HALT: begin
                    d_d.cmd.immediate_halt_cmd = 1'b1;
                end
                CMD_DECELERATE_HALT: begin
                    d_d.cmd.decelerate_halt_cmd = 1'b1;
                end
                CMD_SAFE_PARK: begin
                    d_d.cmd.safe_park_cmd = 1'b1;
                end
                CMD_CONTINUOUS_RUN: begin
                    d_d.cmd.continuous_run_cmd = 1'b1;
                end
                CMD_ZERO_ACTUAL_POS: begin
                    d_d.cmd.zero_actual_pos_cmd = 1'b1;
                end
                CMD_RELOAD_DEFAULTS: begin
                    d_d.cmd.reload_defaults_cmd = 1'b1;
                end
                CMD_NVM_PROGRAM: begin
                    d_d.cmd.nvm_program_cmd = 1'b1;
                end
                CMD_TWO_STAGE_MOVE: begin
                    d_d.cmd.two_stage_move_cmd = 1'b1;
                end
                CMD_TARGET_WRITE: begin
                    d_d.cmd.target_write_cmd = 1'b1;
                end
                CMD_MOTOR_CONFIG_WRITE: begin
                    d_d.cmd.motor_config_write_cmd = 1'b1;
                end
                CMD_STALL_CONFIG_WRITE: begin
                    d_d.cmd.stall_config_write_cmd = 1'b1;
                end
                CMD_BACK_EMF_PROBE: begin
                    d_d.cmd.back_emf_probe_cmd = 1'b1;
                end
                default: begin
                    d_d.unknown = 1'b1;
                end
            endcase
        end

        // a fault still present when the query clears it stays latched
        d_d.flags = sbd_flags_t'((d_q.flags & ~{$bits(sbd_flags_t){clr}}) | fault_evt);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            d_q <= '0;
        end else begin
            d_q <= d_d;
        end
    end

    assign cmd = d_q.cmd;
    assign cmd_valid = d_q.valid;
    assign cmd_unknown = d_q.unknown;
    assign cmd_general_call = d_q.gc;
    assign last_cmd = d_q.last;
    assign fault_flags = d_q.flags;
endmodule

// *** verif/sbd_decoder_props.sv ***
// port assertions of the stepper bus command decoder
`timescale 1ns/1ns
module sbd_decoder_props
    import sbd_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire sbd_pkg::sbd_flags_t fault_evt,
    input wire sbd_pkg::sbd_flags_t fault_flags,
    input wire sbd_pkg::sbd_cmd_t cmd,
    input wire logic cmd_valid,
    input wire logic cmd_unknown,
    input wire logic cmd_general_call,
    input wire logic [7:0] last_cmd
);
    import sbd_pkg::*;
    // expected {unknown, strobes} for a command byte
    function automatic logic [15:0] dec(input logic [7:0] c);
        case (c)
            8'h81: dec = 16'h4000;
            8'hfc: dec = 16'h2000;
            8'h82: dec = 16'h1000;
            8'h84: dec = 16'h0800;
            8'h85: dec = 16'h0400;
            8'h86: dec = 16'h0200;
            8'h87: dec = 16'h0100;
            8'h88: dec = 16'h0080;
            8'h89: dec = 16'h0040;
            8'h8b: dec = 16'h0020;
            8'h8f: dec = 16'h0010;
            8'h90: dec = 16'h0008;
            8'h96: dec = 16'h0004;
            8'h97: dec = 16'h0002;
            8'h9f: dec = 16'h0001;
            default: dec = 16'h8000;
        endcase
    endfunction
    sequence ack_begin;
        $rose(sda_oe);
    endsequence
    sequence ack_stands;
        sda_oe [*8];
    endsequence
    ack_hold_a: assert property (@(posedge link_clk) disable iff (!rstn) ack_begin |-> ack_stands)
        else $error("acknowledge dropped early");
    oe_scl_low_a: assert property (@(posedge link_clk) disable iff (!rstn) $changed(sda_oe) |-> !scl_i)
        else $error("data line moved while clock high");
    drive_low_a: assert property (@(posedge link_clk) disable iff (!rstn) sda_oe |-> sda_o == SDA_DRIVE_LEVEL)
        else $error("acknowledge not low");
    cmd_decode_a: assert property (@(posedge clock) disable iff (!rstn) cmd_valid |-> {cmd_unknown, cmd} == dec(last_cmd))
        else $error("command strobe does not match byte");
    strobe_pulse_a: assert property (@(posedge clock) disable iff (!rstn) cmd_valid |=> !cmd_valid && cmd == '0)
        else $error("strobe longer than one cycle");
    quiet_strobe_a: assert property (@(posedge clock) disable iff (!rstn) !cmd_valid |-> cmd == '0 && !cmd_unknown)
        else $error("strobe without valid");
    cmd_hold_a: assert property (@(posedge clock) disable iff (!rstn)
        !cmd_valid |-> $stable(last_cmd) && $stable(cmd_general_call))
        else $error("command byte changed without valid");
    status_clear_a: assert property (@(posedge clock) disable iff (!rstn)
        cmd.complete_status_query_cmd |-> fault_flags == $past(fault_evt))
        else $error("status query left flags set");
    flag_set_a: assert property (@(posedge clock) disable iff (!rstn)
        1'b1 |=> (fault_flags & $past(fault_evt)) == $past(fault_evt))
        else $error("fault event not latched");
    flag_sticky_a: assert property (@(posedge clock) disable iff (!rstn)
        !cmd.complete_status_query_cmd |-> (fault_flags & $past(fault_flags)) == $past(fault_flags))
        else $error("flag cleared without status query");
endmodule
bind sbd_decoder sbd_decoder_props i_sbd_decoder_props (.clock(clock), .rstn(rstn), .link_clk(link_clk),
    .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .fault_evt(fault_evt), .fault_flags(fault_flags),
    .cmd(cmd), .cmd_valid(cmd_valid), .cmd_unknown(cmd_unknown), .cmd_general_call(cmd_general_call),
    .last_cmd(last_cmd));

// *** verif/sbd_i2c_master.sv ***
// behavioural bus master; both lines are open drain with pull-up, so release means 1
`timescale 1ns/1ns
module sbd_i2c_master #(
    parameter int H = 90
) (
    output logic scl,
    output logic sda,
    input wire logic sda_in
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic pulse();
        #(H/2);
        scl = 1'b1;
        #H;
        scl = 1'b0;
        #(H/2);
    endtask
    // also serves as repeated start: data rises while the clock is still low
    task automatic start();
        sda = 1'b1;
        #(H/2);
        scl = 1'b1;
        #H;
        sda = 1'b0;
        #H;
        scl = 1'b0;
        #(H/2);
    endtask
    task automatic stop();
        sda = 1'b0;
        #(H/2);
        scl = 1'b1;
        #H;
        sda = 1'b1;
        #H;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda = b[i];
            pulse();
        end
        sda = 1'b1;
        #(H/2);
        scl = 1'b1;
        #(H/2);
        ack = !sda_in;
        #(H/2);
        scl = 1'b0;
        #(H/2);
    endtask
    task automatic rbyte(output logic [7:0] b, input logic nack);
        sda = 1'b1;
        for (int i = 0; i < 8; i++) begin
            #(H/2);
            scl = 1'b1;
            #(H/2);
            b = {b[6:0], sda_in};
            #(H/2);
            scl = 1'b0;
            #(H/2);
        end
        sda = nack;
        pulse();
    endtask
endmodule

// *** verif/tb_sbd_decoder.sv ***
// self-checking bench of the stepper bus command decoder
`timescale 1ns/1ns
module tb_sbd_decoder;
    import sbd_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic link_clk = 1'b0;
    logic hw = 1'b0;
    logic [3:0] prog = 4'h0;
    sbd_flags_t fault_evt = '0;
    sbd_flags_t fault_flags;
    sbd_cmd_t cmd;
    sbd_cmd_t cap_cmd;
    logic cmd_valid, cmd_unknown, cmd_general_call, sda_o, sda_oe, m_scl, m_sda, sda_line, cap_unk;
    logic [7:0] last_cmd;
    int n_mismatch = 0;
    int checks = 0;
    int n_valid = 0;
    always #20 clock = ~clock;
    always #3 link_clk = ~link_clk;
    assign sda_line = m_sda & (sda_oe ? sda_o : 1'b1);
    sbd_i2c_master i_sbd_i2c_master (.scl(m_scl), .sda(m_sda), .sda_in(sda_line));
    sbd_decoder i_sbd_decoder (.clock(clock), .rstn(rstn), .link_clk(link_clk), .scl_i(m_scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .hardwired_address_pin(hw), .prog_addr_bit_3(prog[3]),
        .prog_addr_bit_2(prog[2]), .prog_addr_bit_1(prog[1]), .prog_addr_bit_0(prog[0]), .fault_evt(fault_evt),
        .fault_flags(fault_flags), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_unknown(cmd_unknown),
        .cmd_general_call(cmd_general_call), .last_cmd(last_cmd));
    always @(posedge clock) begin
        if (cmd_valid === 1'b1) begin
            cap_cmd <= cmd;
            cap_unk <= cmd_unknown;
            n_valid <= n_valid + 1;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic [7:0] own(input logic rd);
        own = {2'b11, prog, hw, rd};
    endfunction
    task automatic set_addr(input logic [4:0] v);
        @(negedge clock);
        prog <= v[4:1];
        hw <= v[0];
        repeat (4) @(negedge clock);
    endtask
    task automatic frame(input logic [7:0] a, input logic [7:0] c, input logic [1:0] exp_ack, input int exp_n);
        logic ack0, ack1;
        int n0;
        n0 = n_valid;
        ack1 = 1'b0;
        i_sbd_i2c_master.start();
        i_sbd_i2c_master.wbyte(a, ack0);
        if (ack0)
            i_sbd_i2c_master.wbyte(c, ack1);
        i_sbd_i2c_master.stop();
        repeat (8) @(posedge clock);
        chk({ack0, ack1}, exp_ack);
        chk(n_valid - n0, exp_n);
    endtask
    task automatic t_codes();
        logic [7:0] codes [15] = '{8'h81, 8'hfc, 8'h82, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8b, 8'h8f,
            8'h90, 8'h96, 8'h97, 8'h9f};
        for (int i = 0; i < 15; i++) begin
            set_addr(i[4:0] ^ 5'h15);
            frame(own(1'b0), codes[i], 2'b11, 1);
            chk(cap_cmd, 15'h4000 >> i);
            chk({cmd_general_call, last_cmd}, {1'b0, codes[i]});
        end
    endtask
    task automatic t_general_call();
        logic [7:0] bad [4] = '{8'h80, 8'h40, 8'h20, 8'h02};
        frame(8'h00, 8'h86, 2'b11, 1);
        chk({cmd_general_call, cap_cmd}, {1'b1, 15'h0200});
        frame(8'h01, 8'h86, 2'b00, 0);
        // a single wrong address bit must be enough to stay silent
        for (int i = 0; i < 4; i++)
            frame(own(1'b0) ^ bad[i], 8'h81, 2'b00, 0);
    endtask
    task automatic t_flags();
        @(negedge clock);
        fault_evt <= '1;
        @(negedge clock);
        fault_evt <= '0;
        chk(fault_flags, 9'h1ff);
        frame(own(1'b0), 8'h80, 2'b11, 1);
        chk({cap_unk, cap_cmd}, {1'b1, 15'h0});
        chk({fault_flags, last_cmd}, {9'h1ff, 8'h80});
        // an event still present during the clear must stay latched
        @(negedge clock);
        fault_evt <= 9'h001;
        frame(own(1'b0), 8'h81, 2'b11, 1);
        chk(fault_flags, 9'h001);
        @(negedge clock);
        fault_evt <= '0;
        frame(own(1'b0), 8'h81, 2'b11, 1);
        chk(fault_flags, 9'h0);
    endtask
    task automatic t_limit();
        logic a;
        logic [8:0] acks;
        i_sbd_i2c_master.start();
        for (int k = 0; k < 9; k++) begin
            i_sbd_i2c_master.wbyte(k == 0 ? own(1'b0) : (k == 1 ? 8'h89 : 8'h5a), a);
            acks[k] = a;
        end
        i_sbd_i2c_master.stop();
        chk(acks, 9'h0ff);
    endtask
    task automatic t_read();
        logic a;
        logic [7:0] b;
        frame(own(1'b0), 8'h82, 2'b11, 1);
        i_sbd_i2c_master.start();
        i_sbd_i2c_master.wbyte(own(1'b1), a);
        i_sbd_i2c_master.rbyte(b, 1'b1);
        i_sbd_i2c_master.stop();
        chk({a, b}, 9'h1ff);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        chk({fault_flags, cmd}, 0);
        chk({last_cmd, cmd_valid, cmd_unknown, cmd_general_call, sda_oe}, 0);
        @(negedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        t_codes();
        t_general_call();
        t_flags();
        t_limit();
        t_read();
        conclude();
    end
    // the run needs roughly 120 us; a hang is cut well beyond that
    initial begin
        #1000000;
        n_mismatch++;
        conclude();
    end
endmodule
